// File: heater_alarm_pkg.sv
// Package for the heater current alarm logic: value encodings and timing.
// Assumes currents arrive as unsigned tenths of an ampere.
package heater_alarm_pkg;
  localparam int unsigned CUR_W = 16;
  typedef logic [CUR_W-1:0] current_t;
  // Threshold range limits, tenths of an ampere
  localparam current_t THRESH_MIN = 16'h0000;      // 0.0 A
  localparam current_t THRESH_MAX = 16'h01F4;      // 50.0 A
  localparam current_t OPEN_RESET = 16'h0000;      // 0.0 A
  localparam current_t OVER_RESET = 16'h01F4;      // 50.0 A
  localparam current_t SHORT_RESET = 16'h01F4;     // 50.0 A
  // Leakage reading span and overrange code
  localparam current_t LEAK_MAX = 16'h0226;        // 55.0 A
  localparam current_t LEAK_OVERRANGE = 16'hFFFF;
  // Off interval under which short detection is blind
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned SHORT_BLIND_MS = 100;
  localparam int unsigned SHORT_BLIND_CYCLES = SHORT_BLIND_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned OFF_CNT_W = 25;
endpackage

// File: heater_current_alarm_logic.sv
// Alarm decisions for heater channel 2 and both leakage channels.
// Assumes current samples are synchronous to i_clock, in tenths of an ampere.
//
// Summary of operation
// - Open alarm when current below threshold
// - Open threshold 0.0 off, 50.0 on
// - Open threshold 0.0 to 50.0, default 0.0
// - Overcurrent alarm when current exceeds threshold
// - Overcurrent threshold 50.0 off, 0.0 on
// - Overcurrent threshold 0.0 to 50.0, default 50.0
// - Overcurrent needs enable, alarm 1, two inputs
// - Leakage sampled while heater drive off
// - No short detection if off time <=100 ms
// - Leakage span 55.0, above shows FFFF
// - Short alarm lights lamp, blinks display while its reading is shown
// - Short alarm when leakage exceeds threshold
// - Short threshold 0.0 to 50.0, default 50.0
// - Leakage needs enable, alarm 1; ch2 two inputs
// - Short threshold 50.0 off, 0.0 on
`timescale 1ns/1ps
module heater_current_alarm_logic
  import heater_alarm_pkg::*;
#(
  parameter int unsigned BLIND_CYCLES = SHORT_BLIND_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Configuration
  input wire logic i_open_enable,
  input wire logic i_over_enable,
  input wire logic i_short_enable,
  input wire logic i_alarm1_assigned,
  input wire logic i_two_ct,
  // Threshold writes
  input wire logic i_open_thresh_we,
  input wire logic [CUR_W-1:0] i_open_thresh,
  input wire logic i_over_thresh_we,
  input wire logic [CUR_W-1:0] i_over_thresh,
  input wire logic i_short_thresh_ch1_we,
  input wire logic [CUR_W-1:0] i_short_thresh_ch1,
  input wire logic i_short_thresh_ch2_we,
  input wire logic [CUR_W-1:0] i_short_thresh_ch2,
  // Measurements
  input wire logic [CUR_W-1:0] i_heater_current_ch2,
  input wire logic i_drive_on_ch1,
  input wire logic [CUR_W-1:0] i_ct_current_ch1,
  input wire logic i_drive_on_ch2,
  input wire logic [CUR_W-1:0] i_ct_current_ch2,
  // Display state
  input wire logic i_show_leak_ch1,
  input wire logic i_show_leak_ch2,
  // Alarms and readings
  output logic o_heater_open_detect,
  output logic o_overcurrent,
  output logic o_heater_short_ch1,
  output logic o_heater_short_ch2,
  output logic [CUR_W-1:0] o_leakage_reading_ch1,
  output logic [CUR_W-1:0] o_leakage_reading_ch2,
  output logic o_fault_lamp,
  output logic o_display_blink,
  // Stored thresholds
  output logic [CUR_W-1:0] o_open_thresh,
  output logic [CUR_W-1:0] o_over_thresh,
  output logic [CUR_W-1:0] o_short_thresh_ch1,
  output logic [CUR_W-1:0] o_short_thresh_ch2
);

  // Out-of-range writes are clamped rather than dropped
  function automatic current_t clamp_thresh(input current_t v);
    clamp_thresh = (v > THRESH_MAX) ? THRESH_MAX : v;
  endfunction

  // Leakage value shown, overrange replaced by code
  function automatic current_t leak_show(input current_t v);
    leak_show = (v > LEAK_MAX) ? LEAK_OVERRANGE : v;
  endfunction

  // Short compare with forced ends of the range
  function automatic logic short_cmp(input current_t leak, input current_t th);
    if (th == THRESH_MAX) begin
      short_cmp = 1'b0;
    end else if (th == THRESH_MIN) begin
      short_cmp = 1'b1;
    end else begin
      short_cmp = leak > th;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Threshold storage
  current_t open_q, open_d, over_q, over_d, sth1_q, sth1_d, sth2_q, sth2_d;

  always_comb begin
    open_d = i_open_thresh_we ? clamp_thresh(i_open_thresh) : open_q;
    over_d = i_over_thresh_we ? clamp_thresh(i_over_thresh) : over_q;
    sth1_d = i_short_thresh_ch1_we ? clamp_thresh(i_short_thresh_ch1) : sth1_q;
    sth2_d = i_short_thresh_ch2_we ? clamp_thresh(i_short_thresh_ch2) : sth2_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      open_q <= OPEN_RESET;
      over_q <= OVER_RESET;
      sth1_q <= SHORT_RESET;
      sth2_q <= SHORT_RESET;
    end else begin
      open_q <= open_d;
      over_q <= over_d;
      sth1_q <= sth1_d;
      sth2_q <= sth2_d;
    end
  end

  assign o_open_thresh = open_q;
  assign o_over_thresh = over_q;
  assign o_short_thresh_ch1 = sth1_q;
  assign o_short_thresh_ch2 = sth2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Leakage sampling and off-time measurement, one slice per channel
  logic short_act1, short_act2;
  current_t leak1_q, leak1_d, leak2_q, leak2_d;
  logic [OFF_CNT_W-1:0] off1_q, off1_d, off2_q, off2_d;
  logic long1_q, long1_d, long2_q, long2_d;

  // Channel 2 leakage also needs the second current input
  assign short_act1 = i_short_enable && i_alarm1_assigned;
  assign short_act2 = short_act1 && i_two_ct;

  // Reading only follows the input while the drive is off; the counter
  // saturates so a long off period never wraps back into the blind zone
  always_comb begin
    leak1_d = (!i_drive_on_ch1 && short_act1) ? leak_show(i_ct_current_ch1) : leak1_q;
    leak2_d = (!i_drive_on_ch2 && short_act2) ? leak_show(i_ct_current_ch2) : leak2_q;
    off1_d = i_drive_on_ch1 ? '0 : ((off1_q == '1) ? off1_q : off1_q + 1'b1);
    off2_d = i_drive_on_ch2 ? '0 : ((off2_q == '1) ? off2_q : off2_q + 1'b1);
    long1_d = !i_drive_on_ch1 && (32'(off1_q) >= BLIND_CYCLES);
    long2_d = !i_drive_on_ch2 && (32'(off2_q) >= BLIND_CYCLES);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      leak1_q <= '0;
      leak2_q <= '0;
      off1_q <= '0;
      off2_q <= '0;
      long1_q <= 1'b0;
      long2_q <= 1'b0;
    end else begin
      leak1_q <= leak1_d;
      leak2_q <= leak2_d;
      off1_q <= off1_d;
      off2_q <= off2_d;
      long1_q <= long1_d;
      long2_q <= long2_d;
    end
  end

  assign o_leakage_reading_ch1 = leak1_q;
  assign o_leakage_reading_ch2 = leak2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm decisions, registered
  logic open_al_q, open_al_d, over_al_q, over_al_d;
  logic sh1_q, sh1_d, sh2_q, sh2_d;
  logic over_act;

  assign over_act = i_over_enable && i_alarm1_assigned && i_two_ct;

  // Short alarm holds its state across blind periods instead of clearing
  always_comb begin
    if (!i_open_enable || open_q == THRESH_MIN) begin
      open_al_d = 1'b0;
    end else if (open_q == THRESH_MAX) begin
      open_al_d = 1'b1;
    end else begin
      open_al_d = i_heater_current_ch2 < open_q;
    end
    if (!over_act || over_q == THRESH_MAX) begin
      over_al_d = 1'b0;
    end else if (over_q == THRESH_MIN) begin
      over_al_d = 1'b1;
    end else begin
      over_al_d = i_heater_current_ch2 > over_q;
    end
    sh1_d = !short_act1 ? 1'b0 : (long1_q ? short_cmp(leak1_q, sth1_q) : sh1_q);
    sh2_d = !short_act2 ? 1'b0 : (long2_q ? short_cmp(leak2_q, sth2_q) : sh2_q);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      open_al_q <= 1'b0;
      over_al_q <= 1'b0;
      sh1_q <= 1'b0;
      sh2_q <= 1'b0;
    end else begin
      open_al_q <= open_al_d;
      over_al_q <= over_al_d;
      sh1_q <= sh1_d;
      sh2_q <= sh2_d;
    end
  end

  assign o_heater_open_detect = open_al_q;
  assign o_overcurrent = over_al_q;
  assign o_heater_short_ch1 = sh1_q;
  assign o_heater_short_ch2 = sh2_q;
  // Lamp for any short; blink while the alarmed reading is shown
  assign o_fault_lamp = sh1_q || sh2_q;
  assign o_display_blink = (sh1_q && i_show_leak_ch1) || (sh2_q && i_show_leak_ch2);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_open_cmp;
    @(posedge i_clock) disable iff (i_rst)
      (i_open_enable && open_q != THRESH_MIN && open_q != THRESH_MAX && i_heater_current_ch2 < open_q)
      |=> o_heater_open_detect;
  endproperty
  a_open_cmp: assert property (p_open_cmp) else $error("open alarm missed");

  property p_open_force;
    @(posedge i_clock) disable iff (i_rst)
      (open_q == THRESH_MIN) |=> !o_heater_open_detect;
  endproperty
  a_open_force: assert property (p_open_force) else $error("open alarm not forced off");

  property p_open_range;
    @(posedge i_clock) disable iff (i_rst) open_q <= THRESH_MAX;
  endproperty
  a_open_range: assert property (p_open_range) else $error("open threshold out of range");

  property p_over_cmp;
    @(posedge i_clock) disable iff (i_rst)
      (over_act && over_q != THRESH_MAX && i_heater_current_ch2 > over_q) |=> o_overcurrent;
  endproperty
  a_over_cmp: assert property (p_over_cmp) else $error("overcurrent missed");

  property p_over_gate;
    @(posedge i_clock) disable iff (i_rst) (!over_act || over_q == THRESH_MAX) |=> !o_overcurrent;
  endproperty
  a_over_gate: assert property (p_over_gate) else $error("overcurrent not gated");

  property p_over_range;
    @(posedge i_clock) disable iff (i_rst) over_q <= THRESH_MAX;
  endproperty
  a_over_range: assert property (p_over_range) else $error("overcurrent threshold out of range");

  property p_leak_over;
    @(posedge i_clock) disable iff (i_rst)
      (!i_drive_on_ch1 && short_act1 && i_ct_current_ch1 > LEAK_MAX) |=> o_leakage_reading_ch1 == LEAK_OVERRANGE;
  endproperty
  a_leak_over: assert property (p_leak_over) else $error("overrange code missing");

  property p_leak_hold;
    @(posedge i_clock) disable iff (i_rst) i_drive_on_ch1 |=> $stable(o_leakage_reading_ch1);
  endproperty
  a_leak_hold: assert property (p_leak_hold) else $error("leakage sampled while driving");

  property p_short_blind;
    @(posedge i_clock) disable iff (i_rst)
      (short_act1 && !long1_q) |=> (o_heater_short_ch1 == $past(o_heater_short_ch1));
  endproperty
  a_short_blind: assert property (p_short_blind) else $error("short detected in blind window");

  property p_lamp;
    @(posedge i_clock) disable iff (i_rst) (o_heater_short_ch1 && i_show_leak_ch1) |-> (o_fault_lamp && o_display_blink);
  endproperty
  a_lamp: assert property (p_lamp) else $error("fault lamp dark");

  property p_short_gate;
    @(posedge i_clock) disable iff (i_rst) (!short_act1 || sth1_q == THRESH_MAX) |=> !o_heater_short_ch1;
  endproperty
  a_short_gate: assert property (p_short_gate) else $error("short alarm not gated");

endmodule

// File: testbench.sv
// Self-checking bench for the heater current alarm logic.
// Assumes the design package and module are compiled first; no partner model.
`timescale 1ns/1ps
module testbench;
  import heater_alarm_pkg::*;
  localparam int BLIND = 8;
  logic i_clock, i_rst, i_open_enable, i_over_enable, i_short_enable, i_alarm1_assigned, i_two_ct;
  logic i_open_thresh_we, i_over_thresh_we, i_short_thresh_ch1_we, i_short_thresh_ch2_we;
  logic i_drive_on_ch1, i_drive_on_ch2, i_show_leak_ch1, i_show_leak_ch2;
  current_t i_open_thresh, i_over_thresh, i_short_thresh_ch1, i_short_thresh_ch2;
  current_t i_heater_current_ch2, i_ct_current_ch1, i_ct_current_ch2;
  logic o_heater_open_detect, o_overcurrent, o_heater_short_ch1, o_heater_short_ch2;
  logic o_fault_lamp, o_display_blink;
  current_t o_leakage_reading_ch1, o_leakage_reading_ch2;
  current_t o_open_thresh, o_over_thresh, o_short_thresh_ch1, o_short_thresh_ch2;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////
  // Short blind window shrunk so the run stays brief
  heater_current_alarm_logic #(.BLIND_CYCLES(BLIND)) i_heater_current_alarm_logic (
    .i_clock, .i_rst, .i_open_enable, .i_over_enable, .i_short_enable, .i_alarm1_assigned, .i_two_ct,
    .i_open_thresh_we, .i_open_thresh, .i_over_thresh_we, .i_over_thresh,
    .i_short_thresh_ch1_we, .i_short_thresh_ch1, .i_short_thresh_ch2_we, .i_short_thresh_ch2,
    .i_heater_current_ch2, .i_drive_on_ch1, .i_ct_current_ch1, .i_drive_on_ch2, .i_ct_current_ch2,
    .i_show_leak_ch1, .i_show_leak_ch2, .o_heater_open_detect, .o_overcurrent,
    .o_heater_short_ch1, .o_heater_short_ch2, .o_leakage_reading_ch1, .o_leakage_reading_ch2,
    .o_fault_lamp, .o_display_blink, .o_open_thresh, .o_over_thresh, .o_short_thresh_ch1,
    .o_short_thresh_ch2);
  ////////////////////////////////////////////////////////////////
  // Clock, and a hang guard well above the expected run length
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  // Wide enough for an alarm bit joined to a reading
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Lets edges pass, then samples settled outputs
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // One-cycle write pulse; index picks the threshold
  task automatic wr(input int k, input current_t v);
    @(posedge i_clock);
    i_open_thresh_we <= (k == 0);
    i_over_thresh_we <= (k == 1);
    i_short_thresh_ch1_we <= (k == 2);
    i_short_thresh_ch2_we <= (k == 3);
    i_open_thresh <= v;
    i_over_thresh <= v;
    i_short_thresh_ch1 <= v;
    i_short_thresh_ch2 <= v;
    @(posedge i_clock);
    {i_open_thresh_we, i_over_thresh_we, i_short_thresh_ch1_we, i_short_thresh_ch2_we} <= 4'h0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults();
    check(o_open_thresh, THRESH_MIN);
    check(o_over_thresh, THRESH_MAX);
    check(o_short_thresh_ch1, THRESH_MAX);
    check(o_short_thresh_ch2, THRESH_MAX);
  endtask
  task automatic t_open();
    wr(0, 16'h0064);
    i_heater_current_ch2 <= 16'h0032;
    wait_n(3);
    check(o_heater_open_detect, 1);
    @(posedge i_clock) i_heater_current_ch2 <= 16'h0096;
    wait_n(3);
    check(o_heater_open_detect, 0);
    wr(0, 16'h01F4);
    i_heater_current_ch2 <= 16'h0258;
    wait_n(3);
    check(o_heater_open_detect, 1);
    wr(0, 16'h0000);
    i_heater_current_ch2 <= 16'h0000;
    wait_n(3);
    check(o_heater_open_detect, 0);
  endtask
  task automatic t_over();
    wr(1, 16'h0258);
    wait_n(1);
    check(o_over_thresh, THRESH_MAX);
    wr(1, 16'h0000);
    wait_n(3);
    check(o_overcurrent, 1);
    @(posedge i_clock) i_two_ct <= 1'b0;
    wait_n(3);
    check(o_overcurrent, 0);
    wr(1, 16'h0064);
    i_two_ct <= 1'b1;
    i_heater_current_ch2 <= 16'h0096;
    wait_n(3);
    check(o_overcurrent, 1);
    wr(1, 16'h01F4);
    i_heater_current_ch2 <= 16'h0258;
    wait_n(3);
    check(o_overcurrent, 0);
  endtask
  task automatic t_leak_short();
    wr(2, 16'h0064);
    i_ct_current_ch1 <= 16'h00C8;
    i_drive_on_ch1 <= 1'b0;
    wait_n(4);
    check(o_leakage_reading_ch1, 16'h00C8);
    check(o_heater_short_ch1, 0);
    @(posedge i_clock) i_drive_on_ch1 <= 1'b1;
    i_ct_current_ch1 <= 16'h012C;
    wait_n(3);
    check(o_leakage_reading_ch1, 16'h00C8);
    @(posedge i_clock) i_drive_on_ch1 <= 1'b0;
    i_ct_current_ch1 <= 16'h0227;
    wait_n(BLIND + 4);
    check(o_leakage_reading_ch1, LEAK_OVERRANGE);
    check(o_heater_short_ch1, 1);
    check({o_fault_lamp, o_display_blink}, 2'h3);
    check({o_heater_short_ch2, o_leakage_reading_ch2}, 32'h0);
    @(posedge i_clock) i_ct_current_ch1 <= 16'h0226;
    wr(2, 16'h01F4);
    wait_n(4);
    check(o_leakage_reading_ch1, LEAK_MAX);
    check(o_heater_short_ch1, 0);
    wr(2, 16'h0000);
    i_ct_current_ch1 <= 16'h0000;
    wait_n(4);
    check(o_heater_short_ch1, 1);
    @(posedge i_clock) i_short_enable <= 1'b0;
    wait_n(3);
    check({o_heater_short_ch1, o_fault_lamp}, 2'h0);
  endtask
  // Second leakage channel alarms alone; channel 1 kept quiet at its off end
  task automatic t_short_ch2();
    wr(2, 16'h01F4);
    wr(3, 16'h0064);
    i_short_enable <= 1'b1;
    i_drive_on_ch2 <= 1'b0;
    i_ct_current_ch2 <= 16'h012C;
    {i_show_leak_ch1, i_show_leak_ch2} <= 2'h1;
    wait_n(4);
    check(o_heater_short_ch2, 0);
    check(o_leakage_reading_ch2, 16'h012C);
    wait_n(BLIND);
    check(o_heater_short_ch2, 1);
    check({o_fault_lamp, o_display_blink}, 2'h3);
    check({o_heater_short_ch1, o_leakage_reading_ch1}, 32'h0);
    @(posedge i_clock) i_two_ct <= 1'b0;
    wait_n(3);
    check(o_heater_short_ch2, 0);
  endtask
  // Reset in mid-run brings stored thresholds back to their defaults
  task automatic t_mid_reset();
    @(posedge i_clock) i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    wait_n(1);
    check(o_short_thresh_ch2, THRESH_MAX);
    check(o_open_thresh, THRESH_MIN);
    check(o_over_thresh, THRESH_MAX);
    check({o_heater_short_ch2, o_leakage_reading_ch2}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_open_thresh_we, i_over_thresh_we, i_short_thresh_ch1_we, i_short_thresh_ch2_we} = 4'h0;
    {i_open_thresh, i_over_thresh, i_short_thresh_ch1, i_short_thresh_ch2} = '0;
    {i_heater_current_ch2, i_ct_current_ch1, i_ct_current_ch2} = '0;
    {i_open_enable, i_over_enable, i_short_enable, i_alarm1_assigned, i_two_ct} = 5'h1F;
    {i_drive_on_ch1, i_drive_on_ch2, i_show_leak_ch1, i_show_leak_ch2} = 4'b1110;
    i_rst = 1'b1;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    wait_n(1);
    t_defaults();
    t_open();
    t_over();
    t_leak_short();
    t_short_ch2();
    t_mid_reset();
    report_and_stop();
  end
endmodule
